// *** hdl/udi_edge.sv ***
// edge detector for one level input of the device interrupt status block
// assumes the level is already synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module udi_edge (
    input wire logic clock,
    input wire logic nrst,
    input wire logic level,
    output logic rise,
    output logic fall
);

    // ****************************************
    // previous sample
    // ****************************************
    logic prev; // level one cycle ago

    // hold last sample; zero at reset, so a level high at release counts as a rise
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    // one-cycle pulses on each transition
    assign rise = level & ~prev;
    assign fall = ~level & prev;

endmodule
`default_nettype wire

// *** hdl/udi_pkg.sv ***
// constants shared by the device interrupt status block
// assumes a 40 MHz controller clock and a 12-bit register byte address
package udi_pkg;

    // ****************************************
    // bus geometry
    // ****************************************
    localparam int ADDR_W = 12;                   // byte address width of the register port
    localparam int DATA_W = 32;                   // register data width

    // ****************************************
    // register byte addresses
    // ****************************************
    localparam logic [11:0] FLAGS_OFFSET = 12'h218; // device_interrupt_flags
    localparam logic [11:0] ID_OFFSET = 12'h270;    // device_identification
    localparam logic [11:0] MASK_OFFSET = 12'h2a0;  // interrupt mask, same layout as the flags

    // ****************************************
    // flag field positions
    // ****************************************
    localparam int BUFFER_LSB = 10;               // control_receive_flag, lowest buffer flag
    localparam int BUFFER_MSB = 25;               // ep7_transmit_flag, highest buffer flag
    localparam int BUFFER_N = 16;                 // eight endpoints, two directions each
    localparam int SETUP_BIT = 8;                 // setup_received_flag
    localparam int VBUS_BIT = 7;                  // bus supply rose
    localparam int DMA_BIT = 6;                   // dma reason changed
    localparam int SPEED_BIT = 5;                 // speed_status_flag
    localparam int RESUME_BIT = 4;                // resume detected
    localparam int SUSPEND_BIT = 3;               // suspend_flag
    localparam int PSEUDO_BIT = 2;                // pseudo_frame_flag
    localparam int SOF_BIT = 1;                   // frame start received
    localparam int BUS_RESET_BIT = 0;             // bus_reset_flag

    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [31:0] FLAGS_RESET = 32'h0000_0000;    // all flags clear at power on
    localparam logic [31:0] MASK_RESET = 32'h0000_0000;     // all sources masked at power on
    localparam logic [31:0] FLAG_IMPL = 32'h03ff_fdff;      // bits 31..26 and 9 are reserved
    localparam logic [31:0] BUS_RESET_KEEP = 32'h0000_0001; // only the bus reset flag survives it
    localparam logic [31:0] READ_IDLE = 32'h0000_0000;      // read data outside the answer cycle

    // ****************************************
    // timing
    // ****************************************
    localparam int CLOCK_PERIOD_PS = 25000;       // 40 MHz
    localparam int FS_TICK_US = 1000;             // full speed pseudo frame period, 1 ms
    localparam int HS_TICK_US = 125;              // high speed pseudo frame period
    localparam int FS_TICK_CYCLES = FS_TICK_US * 1000000 / CLOCK_PERIOD_PS;
    localparam int HS_TICK_CYCLES = HS_TICK_US * 1000000 / CLOCK_PERIOD_PS;
    localparam int TICK_W = 16;                   // width of the pseudo frame counter

endpackage

// *** hdl/udi_tick.sv ***
// free running pseudo frame timer for the device interrupt status block
// assumes hs_mode is a synchronous level: high while the link runs at high speed
`timescale 1ns/1ps
`default_nettype none
module udi_tick #(
    parameter int FS_CYCLES = udi_pkg::FS_TICK_CYCLES,
    parameter int HS_CYCLES = udi_pkg::HS_TICK_CYCLES
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hs_mode,
    output logic tick
);
    import udi_pkg::*;

    // ****************************************
    // counter
    // ****************************************
    logic [TICK_W-1:0] count; // cycles since the last tick
    logic mode_seen;          // speed mode the count belongs to
    logic [TICK_W-1:0] last;  // terminal count for the current mode

    // terminal count; a period shorter than one cycle is not allowed
    assign last = hs_mode ? TICK_W'(HS_CYCLES - 1) : TICK_W'(FS_CYCLES - 1);

    // tick on terminal count only while the mode is stable
    assign tick = (count == last) && (hs_mode == mode_seen);

    // count up and wrap; a speed change restarts the period, not tied to bus frames
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
            mode_seen <= 1'b0;
        end else begin
            mode_seen <= hs_mode;
            if (hs_mode != mode_seen) begin
                count <= '0;
            end else if (count == last) begin
                count <= '0;
            end else begin
                count <= count + TICK_W'(1);
            end
        end
    end

endmodule
`default_nettype wire

// *** hdl/udi_top.sv ***
// device interrupt status flags, mask and identification word
// assumes all event inputs are synchronous to clock; pulses are one cycle long,
// levels may change at any edge; the register master never issues both strobes at once
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module udi_top #(
    parameter int FS_CYCLES = udi_pkg::FS_TICK_CYCLES,  // full speed pseudo frame period in cycles
    parameter int HS_CYCLES = udi_pkg::HS_TICK_CYCLES,  // high speed pseudo frame period in cycles
    parameter logic [15:0] ID_VERSION = 16'h00a1,       // arbitrary value
    parameter logic [15:0] ID_CONTROLLER = 16'h00c3     // arbitrary value
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [udi_pkg::ADDR_W-1:0] addr,
    input wire logic [udi_pkg::DATA_W-1:0] wdata,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    output logic [udi_pkg::DATA_W-1:0] rdata,
    input wire logic [udi_pkg::BUFFER_N-1:0] buffer_event,
    input wire logic setup_token,
    input wire logic vbus_level,
    input wire logic dma_reason_change,
    input wire logic hs_mode,
    input wire logic suspended,
    input wire logic sof_received,
    input wire logic bus_reset,
    output logic irq
);
    import udi_pkg::*;

    // ****************************************
    // declarations
    // ****************************************
    logic [31:0] flags;        // device_interrupt_flags
    logic [31:0] mask;         // interrupt mask
    logic [31:0] next_flags;   // flags after this cycle
    logic [31:0] set_vec;      // events arriving this cycle
    logic [31:0] clr_vec;      // write-one-to-clear bits this cycle
    logic [31:0] ident;        // device_identification
    logic vbus_rise;           // supply went low to high
    logic hs_rise;             // link went full speed to high speed
    logic hs_fall;             // link left high speed, unused for flags
    logic suspend_flag_rise;           // bus went idle into suspend
    logic suspend_flag_fall;           // bus came back from suspend
    logic vbus_fall;           // supply dropped, not a flag source
    logic pseudo_tick;         // internal frame timer pulse
    logic speed_up;            // qualified speed change event
    logic wr_flags;            // write hits the flag register
    logic wr_mask;             // write hits the mask register

    // ****************************************
    // transition detectors
    // ****************************************

    // supply edge; correct only when the otg logic is disabled by firmware in pure roles
    udi_edge u_vbus_edge (
        .clock(clock),
        .nrst(nrst),
        .level(vbus_level),
        .rise(vbus_rise),
        .fall(vbus_fall)
    );

    // speed mode edges
    udi_edge u_speed_edge (
        .clock(clock),
        .nrst(nrst),
        .level(hs_mode),
        .rise(hs_rise),
        .fall(hs_fall)
    );

    // suspend state edges
    udi_edge u_suspend_flag_edge (
        .clock(clock),
        .nrst(nrst),
        .level(suspended),
        .rise(suspend_flag_rise),
        .fall(suspend_flag_fall)
    );

    // pseudo frame timer, free running against bus frame markers
    udi_tick #(
        .FS_CYCLES(FS_CYCLES),
        .HS_CYCLES(HS_CYCLES)
    ) u_tick (
        .clock(clock),
        .nrst(nrst),
        .hs_mode(hs_mode),
        .tick(pseudo_tick)
    );

    // ****************************************
    // event collection
    // ****************************************

    // a speed rise seen while suspended is not a connection change;
    // dropping to full speed for suspend never raises the flag at all
    assign speed_up = hs_rise & ~suspended;

    // map every event onto its flag position
    always_comb begin
        set_vec = '0;
        set_vec[BUFFER_MSB:BUFFER_LSB] = buffer_event;
        set_vec[SETUP_BIT] = setup_token;
        set_vec[VBUS_BIT] = vbus_rise;
        set_vec[DMA_BIT] = dma_reason_change;
        set_vec[SPEED_BIT] = speed_up;
        set_vec[RESUME_BIT] = suspend_flag_fall;
        set_vec[SUSPEND_BIT] = suspend_flag_rise;
        set_vec[PSEUDO_BIT] = pseudo_tick;
        set_vec[SOF_BIT] = sof_received;
        set_vec[BUS_RESET_BIT] = bus_reset;
    end

    // ****************************************
    // register decode
    // ****************************************
    assign wr_flags = wr_strobe && (addr == FLAGS_OFFSET);
    assign wr_mask = wr_strobe && (addr == MASK_OFFSET);

    // ones written to the flag register clear; reserved positions are ignored
    assign clr_vec = wr_flags ? (wdata & FLAG_IMPL) : 32'h0000_0000;

    // ****************************************
    // flag update
    // ****************************************

    // bus reset wipes every flag except its own; a new event always beats a clear
    always_comb begin
        if (bus_reset) begin
            next_flags = flags & BUS_RESET_KEEP;
        end else begin
            next_flags = flags & ~clr_vec;
        end
        next_flags = (next_flags | set_vec) & FLAG_IMPL;
    end

    // sticky flag register
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags <= FLAGS_RESET;
        end else begin
            flags <= next_flags;
        end
    end

    // mask register; reserved bits cannot be set, so they never gate an interrupt
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mask <= MASK_RESET;
        end else if (wr_mask) begin
            mask <= wdata & FLAG_IMPL;
        end
    end

    // ****************************************
    // identification and read port
    // ****************************************

    // fixed word: version in the upper half, controller identifier below
    assign ident = {ID_VERSION, ID_CONTROLLER};

    // read data live only in the cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= READ_IDLE;
        end else if (rd_strobe) begin
            case (addr)
                FLAGS_OFFSET: begin
                    rdata <= flags;
                end
                MASK_OFFSET: begin
                    rdata <= mask;
                end
                ID_OFFSET: begin
                    rdata <= ident;
                end
                default: begin
                    rdata <= READ_IDLE;
                end
            endcase
        end else begin
            rdata <= READ_IDLE;
        end
    end

    // ****************************************
    // interrupt output
    // ****************************************

    // level output, drops as soon as firmware clears or masks the last source
    assign irq = |(flags & mask);

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // helper: cycles since the last pseudo tick under one stable speed mode
    logic [TICK_W-1:0] gap;
    logic gap_valid;
    logic gap_mode;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            gap <= '0;
            gap_valid <= 1'b0;
            gap_mode <= 1'b0;
        end else begin
            gap_mode <= hs_mode;
            if (hs_mode != gap_mode) begin
                gap <= '0;
                gap_valid <= 1'b0;
            end else if (pseudo_tick) begin
                gap <= '0;
                gap_valid <= 1'b1;
            end else begin
                gap <= gap + TICK_W'(1);
            end
        end
    end

    // a write of ones to the flags followed by a read of them
    sequence s_clear_all;
        wr_strobe && (addr == FLAGS_OFFSET) && (wdata == FLAG_IMPL) && (set_vec == 32'h0000_0000);
    endsequence
    sequence s_read_flags;
        rd_strobe && (addr == FLAGS_OFFSET) && (set_vec == 32'h0000_0000) && !bus_reset;
    endsequence

    a_buffer_flags: assert property (
        (buffer_event != '0) |=> ((flags[BUFFER_MSB:BUFFER_LSB] & $past(buffer_event)) == $past(buffer_event)))
        else $error("buffer event did not set its flag");
    a_setup_flag: assert property (
        setup_token |=> flags[SETUP_BIT])
        else $error("setup token did not set its flag");
    a_vbus_flag: assert property (
        (!$past(vbus_level) && vbus_level) |=> flags[VBUS_BIT])
        else $error("supply rise did not set its flag");
    a_dma_flag: assert property (
        dma_reason_change |=> flags[DMA_BIT])
        else $error("dma reason change did not set its flag");
    a_speed_flag: assert property (
        ($rose(hs_mode) && !suspended) |=> flags[SPEED_BIT])
        else $error("speed change did not set its flag");
    a_speed_quiet: assert property (
        (!flags[SPEED_BIT] && !($rose(hs_mode) && !suspended)) |=> !flags[SPEED_BIT])
        else $error("speed flag set without a high speed change");
    a_resume_flag: assert property (
        $fell(suspended) |=> flags[RESUME_BIT])
        else $error("resume did not set its flag");
    a_suspend_flag: assert property (
        $rose(suspended) |=> flags[SUSPEND_BIT])
        else $error("suspend did not set its flag");
    a_pseudo_flag: assert property (
        pseudo_tick |=> flags[PSEUDO_BIT])
        else $error("pseudo frame tick did not set its flag");
    a_pseudo_period: assert property (
        (pseudo_tick && gap_valid && (hs_mode == gap_mode))
        |-> (gap == (hs_mode ? TICK_W'(HS_CYCLES - 1) : TICK_W'(FS_CYCLES - 1))))
        else $error("pseudo frame period wrong");
    a_sof_flag: assert property (
        sof_received |=> flags[SOF_BIT])
        else $error("frame start did not set its flag");
    a_reset_flag: assert property (
        bus_reset |=> (flags[BUS_RESET_BIT] && (flags[31:1] == $past(set_vec[31:1]))))
        else $error("bus reset handling wrong");
    a_flags_sticky: assert property (
        !bus_reset |=> ((($past(flags) & ~$past(clr_vec)) & ~flags) == 32'h0000_0000))
        else $error("flag dropped without a clear");
    a_clear_read: assert property (
        s_clear_all ##1 s_read_flags |=> (rdata == 32'h0000_0000))
        else $error("flags not cleared by writing ones");
    a_ident_read: assert property (
        (rd_strobe && (addr == ID_OFFSET))
        |=> (rdata == {ID_VERSION, ID_CONTROLLER}) ##1 ((rdata == READ_IDLE) || $past(rd_strobe)))
        else $error("identification word read wrong");

endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// self-checking bench for the device interrupt status block
// assumes udi_pkg is compiled first; short pseudo frame periods keep the run brief
`timescale 1ns/1ps
`default_nettype none
`define CHK(name, exp, got) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        mismatches++; \
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
    end \
end
module tb_top;
    import udi_pkg::*;
    // ****************************************
    // settings and signals
    // ****************************************
    localparam int FS = 40;                       // shortened full speed period
    localparam int HS = 5;                        // shortened high speed period
    localparam logic [15:0] ID_VER = 16'h005a;    // arbitrary value
    localparam logic [15:0] ID_CTL = 16'h00e7;    // arbitrary value
    localparam logic [31:0] NP = 32'hffff_fffb;   // pseudo flag runs free, so flag compares skip it
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_strobe = 1'b0;
    logic rd_strobe = 1'b0;
    logic [31:0] rdata;
    logic irq;
    logic [15:0] buffer_event;
    logic setup_token, vbus_level, dma_reason_change, hs_mode, suspended, sof_received, bus_reset;
    int mismatches = 0;
    int comparisons = 0;
    int cyc_count = 0;
    logic [31:0] exp_flags = 32'h0000_0000;       // model of the flag register
    logic [31:0] exp_mask = 32'h0000_0000;        // model of the mask register

    always #12.5 clock = ~clock;
    // edge counter used to time the pseudo frame ticks
    always @(posedge clock) cyc_count <= cyc_count + 1;

    udi_top #(.FS_CYCLES(FS), .HS_CYCLES(HS), .ID_VERSION(ID_VER), .ID_CONTROLLER(ID_CTL)) dut_u (
        .clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .rdata(rdata), .buffer_event(buffer_event), .setup_token(setup_token),
        .vbus_level(vbus_level), .dma_reason_change(dma_reason_change), .hs_mode(hs_mode),
        .suspended(suspended), .sof_received(sof_received), .bus_reset(bus_reset), .irq(irq));
    udi_host_model host_u (
        .clock(clock), .buffer_event(buffer_event), .setup_token(setup_token), .vbus_level(vbus_level),
        .dma_reason_change(dma_reason_change), .hs_mode(hs_mode), .suspended(suspended),
        .sof_received(sof_received), .bus_reset(bus_reset));

    // ****************************************
    // register bus and closing tasks
    // ****************************************
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
    endtask
    // read data is looked at in the one cycle after the strobe
    task automatic rd_reg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clock);
        addr <= a;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        d = rdata;
    endtask
    // returns the edge count at which irq is first seen high, bounded wait
    task automatic wait_irq(output int t);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clock);
            #1;
            n++;
        end
        t = cyc_count;
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // watchdog: the whole sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clock);
        mismatches++;
        $display("watchdog expired");
        end_sim();
    end

    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        logic [31:0] v;
        logic [31:0] w;
        int lk[7] = '{0, 0, 2, 1, 2, 1, 1};
        int lv[7] = '{1, 0, 1, 1, 0, 0, 1};
        int lb[7] = '{7, -1, 3, -1, 4, -1, 5};
        int t0, t1, t2;
        logic [15:0] b;
        v = $urandom(88);
        repeat (8) @(posedge clock);
        nrst <= 1'b1;
        // identification first, as firmware must before relying on features
        rd_reg(ID_OFFSET, v);
        `CHK("identification first", {ID_VER, ID_CTL}, v)
        rd_reg(FLAGS_OFFSET, v);
        `CHK("flags at reset", FLAGS_RESET, v)
        wr_reg(ID_OFFSET, $urandom);
        rd_reg(ID_OFFSET, v);
        `CHK("identification", {ID_VER, ID_CTL}, v)
        rd_reg(12'h300, v);
        `CHK("unmapped read", READ_IDLE, v)
        $display("test reset_and_id done");
        // each buffer flag alone, cleared again between
        for (int i = 0; i < 16; i++) begin
            host_u.pulse(0, 16'h0001 << i);
            rd_reg(FLAGS_OFFSET, v);
            `CHK("buffer flag", (32'h0000_0400 << i), v & NP)
            wr_reg(FLAGS_OFFSET, 32'h03ff_fc00);
        end
        // setup, dma reason and frame start pulses
        for (int k = 1; k < 4; k++) begin
            host_u.pulse(k, 16'h0000);
            exp_flags[k == 1 ? SETUP_BIT : k == 2 ? DMA_BIT : SOF_BIT] = 1'b1;
            rd_reg(FLAGS_OFFSET, v);
            `CHK("pulse flags", exp_flags, v & NP)
        end
        $display("test pulse_events done");
        // line changes: only the listed transitions raise a flag, hs rise while suspended is ignored
        for (int j = 0; j < 7; j++) begin
            host_u.level(lk[j], lv[j][0]);
            if (lb[j] >= 0) begin
                exp_flags[lb[j]] = 1'b1;
            end
            rd_reg(FLAGS_OFFSET, v);
            `CHK("line flags", exp_flags, v & NP)
        end
        $display("test line_events done");
        // flags hold until cleared by a one; reserved bits stay zero
        repeat (4) begin
            b = 16'($urandom);
            host_u.pulse(0, b);
            exp_flags = exp_flags | {6'h00, b, 10'h000};
            rd_reg(FLAGS_OFFSET, v);
            `CHK("sticky flags", exp_flags, v & NP)
            w = $urandom & FLAG_IMPL;
            wr_reg(FLAGS_OFFSET, w);
            exp_flags = exp_flags & ~(w & FLAG_IMPL);
            rd_reg(FLAGS_OFFSET, v);
            `CHK("cleared flags", exp_flags, v & NP)
        end
        // clear everything and read back with no gap between the strobes
        @(posedge clock);
        addr <= FLAGS_OFFSET;
        wdata <= FLAG_IMPL;
        wr_strobe <= 1'b1;
        @(posedge clock);
        wr_strobe <= 1'b0;
        rd_strobe <= 1'b1;
        @(posedge clock);
        rd_strobe <= 1'b0;
        #1;
        exp_flags = 32'h0000_0000;
        `CHK("back to back clear", exp_flags, rdata & NP)
        $display("test clear done");
        // mask readback and interrupt level
        w = ($urandom & NP) | 32'h0000_0002;
        wr_reg(MASK_OFFSET, w);
        exp_mask = w & FLAG_IMPL;
        rd_reg(MASK_OFFSET, v);
        `CHK("mask", exp_mask, v)
        host_u.pulse(3, 16'h0000);
        #1;
        exp_flags[SOF_BIT] = 1'b1;
        `CHK("irq raised", 1'(|(exp_flags & exp_mask)), irq)
        wr_reg(FLAGS_OFFSET, NP & FLAG_IMPL);
        #1;
        exp_flags = 32'h0000_0000;
        `CHK("irq cleared", 1'b0, irq)
        $display("test mask_irq done");
        // bus reset clears the other flags and raises its own
        host_u.pulse(0, 16'hffff);
        host_u.pulse(1, 16'h0000);
        host_u.pulse(4, 16'h0000);
        exp_flags = 32'h0000_0001;
        rd_reg(FLAGS_OFFSET, v);
        `CHK("bus reset flags", exp_flags, v & NP)
        $display("test bus_reset done");
        // pseudo frame period at full then high speed, timed between two genuine ticks
        wr_reg(MASK_OFFSET, 32'h0000_0004);
        for (int m = 0; m < 2; m++) begin
            host_u.level(1, m[0]);
            wr_reg(FLAGS_OFFSET, 32'h0000_0004);
            wait_irq(t0);
            wr_reg(FLAGS_OFFSET, 32'h0000_0004);
            wait_irq(t1);
            wr_reg(FLAGS_OFFSET, 32'h0000_0004);
            wait_irq(t2);
            `CHK("pseudo period", (m == 1) ? HS : FS, t2 - t1)
        end
        $display("test pseudo_frame done");
        end_sim();
    end
endmodule
`default_nettype wire

// *** verification/udi_host_model.sv ***
// usb side model: drives the link events and line states of the device interrupt status block
// assumes the bench calls its tasks from one process, right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module udi_host_model (
    input wire logic clock,
    output logic [15:0] buffer_event,
    output logic setup_token,
    output logic vbus_level,
    output logic dma_reason_change,
    output logic hs_mode,
    output logic suspended,
    output logic sof_received,
    output logic bus_reset
);
    // ****************************************
    // idle line state
    // ****************************************
    // all lines low at time zero, so no edge is seen when reset is released
    initial begin
        buffer_event = 16'h0000;
        setup_token = 1'b0;
        vbus_level = 1'b0;
        dma_reason_change = 1'b0;
        hs_mode = 1'b0;
        suspended = 1'b0;
        sof_received = 1'b0;
        bus_reset = 1'b0;
    end

    // ****************************************
    // event pulses and line changes
    // ****************************************
    // one-cycle pulse: kind 0 buffers, 1 setup, 2 dma reason, 3 frame start, 4 bus reset
    task automatic pulse(input int kind, input logic [15:0] bufs);
        @(posedge clock);
        case (kind)
            0: buffer_event <= bufs;
            1: setup_token <= 1'b1;
            2: dma_reason_change <= 1'b1;
            3: sof_received <= 1'b1;
            default: bus_reset <= 1'b1;
        endcase
        @(posedge clock);
        buffer_event <= 16'h0000;
        setup_token <= 1'b0;
        dma_reason_change <= 1'b0;
        sof_received <= 1'b0;
        bus_reset <= 1'b0;
    endtask

    // level change: kind 0 supply, 1 high speed, 2 suspended; held until the next call
    // the supply line is driven as a pure peripheral would see it, with the otg logic disabled
    task automatic level(input int kind, input logic v);
        @(posedge clock);
        case (kind)
            0: vbus_level <= v;
            1: hs_mode <= v;
            default: suspended <= v;
        endcase
    endtask
endmodule
`default_nettype wire
